// ===== fcpd_pkg.sv
// Notes on behaviour
// [RULE1] Five independent modulator channels exist, each programmed by its own 8-bit level register.
// [RULE2] A level register holds the 5-bit duty value in bits 7..3 and the 3-bit rate count in bits 2..0.
// [RULE3] The duty value sets the length of the high pulse in every basic cycle of its channel.
// [RULE4] In each frame of eight basic cycles exactly as many extra pulses are inserted as the rate count says.
// [RULE5] The modulator clock is the input clock divided by 2, 4, 8 or 16 for clock-select codes 0 to 3.
// [RULE6] A basic cycle lasts 32 modulator clocks.
// [RULE7] An enabled pin carries its channel output; a disabled pin behaves as plain port I/O.
// [RULE8] Reset clears all five pin enable bits.
// [RULE9] Channel 0 drives port 1 bit 3 and is enabled by config bit 3; channels 1 to 4 follow upward.
// [RULE10] The output is high for duty-value modulator clocks and low for the rest of the 32.
// [RULE11] An inserted pulse adds one modulator clock of high time, spread evenly across the frame.
package fcpd_pkg;
  localparam int NCH = 5;
  localparam int ADDR_W = 12;
  localparam int ADDR_LSB = 2;
  localparam int IDX_W = ADDR_W - ADDR_LSB;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_PINCFG = 10'h09B;
  localparam logic [IDX_W-1:0] IDX_CLKCTL = 10'h0A3;
  localparam logic [IDX_W-1:0] IDX_STATUS = 10'h0B0;
  localparam logic [IDX_W-1:0] IDX_LEVEL [NCH] = '{10'h0A4, 10'h0A5, 10'h0A6, 10'h0A7, 10'h0AC};
  // field layout
  localparam int DUTY_W = 5;
  localparam int RATE_W = 3;
  localparam int DUTY_LSB = 3;
  localparam int SEL_W = 2;
  localparam int PRE_W = 4;
  localparam int PHASE_W = 5;
  localparam int FRAME_W = 3;
  localparam int PIN_BASE = 3;
  localparam int PORT_W = 8;
  localparam logic [SEL_W-1:0] SEL_MAX = 2'h3;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 5'h1F;
  localparam logic [1:0] FRAME_QTR = 2'h2;
  localparam logic [FRAME_W-1:0] FRAME_EIGHTH = 3'h4;
  // reset values
  localparam logic [NCH-1:0] PINEN_RST = 5'h00;
  localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
  localparam logic [7:0] LEVEL_RST = 8'h00;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== fcpd_channel.sv
`timescale 1ns/100ps
module fcpd_channel
  import fcpd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // shared timebase
  input wire logic [PHASE_W-1:0] phase,
  input wire logic [FRAME_W-1:0] frame,
  // programmed level
  input wire logic [7:0] level,
  // modulator output
  output logic modOut
);
  logic [DUTY_W-1:0] duty;
  logic [RATE_W-1:0] rateCnt;
  logic insertNow;
  logic [PHASE_W:0] limit;
  logic modOut_r;
  logic modOut_nxt;

  // split the level into duty and rate count
  assign duty = level[DUTY_LSB +: DUTY_W]; // RULE2
  assign rateCnt = level[RATE_W-1:0]; // RULE2

  // binary rate multiplier: msb hits every odd cycle, lsb once per frame
  assign insertNow = (rateCnt[2] && frame[0]) ||
                     (rateCnt[1] && frame[1:0] == FRAME_QTR) ||
                     (rateCnt[0] && frame == FRAME_EIGHTH); // RULE4 RULE11

  // one extra modulator clock of high time when inserting
  always_comb begin
    limit = {1'b0, duty} + {{PHASE_W{1'b0}}, insertNow}; // RULE11
    modOut_nxt = {1'b0, phase} < limit; // RULE3 RULE10
  end

  // registered so the pin never glitches on compare ripple
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      modOut_r <= 1'b0;
    end else if (ce) begin
      modOut_r <= modOut_nxt;
    end
  end

  assign modOut = modOut_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_duty_high: assert property (ce && {1'b0, phase} < {1'b0, duty} |=> modOut_r) // RULE3
    else $error("output low inside duty time");
  a_tail_low: assert property (ce && phase > duty |=> !modOut_r) // RULE10
    else $error("output high after duty time");
  a_insert_edge: assert property (ce && phase == duty |=> modOut_r == $past(insertNow)) // RULE11
    else $error("inserted clock wrong at duty edge");
  a_rate_zero: assert property (rateCnt == 3'h0 |-> !insertNow) // RULE4
    else $error("insertion with zero rate count");
  a_rate_full: assert property (rateCnt == 3'h7 && frame != 3'h0 |-> insertNow) // RULE4
    else $error("missing insertion with full rate count");
endmodule

// ===== fcpd_top.sv
`timescale 1ns/100ps
module fcpd_top
  import fcpd_pkg::*;
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // axi4-lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // axi4-lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // axi4-lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // port 1 latch side (ordinary i/o)
  input wire logic [PORT_W-1:0] ioOut,
  input wire logic [PORT_W-1:0] ioOe,
  // port 1 pin side
  output logic [PORT_W-1:0] p1Out,
  output logic [PORT_W-1:0] p1Oe
);
  // configuration state
  logic [NCH-1:0] pinEn_r, pinEn_nxt;
  logic [SEL_W-1:0] clkSel_r, clkSel_nxt;
  logic [7:0] level_r [NCH];
  logic [7:0] level_nxt [NCH];
  // write channel state
  logic awHeld_r, awHeld_nxt;
  logic [ADDR_W-1:0] awAddr_r, awAddr_nxt;
  logic wHeld_r, wHeld_nxt;
  logic [7:0] wByte_r, wByte_nxt;
  logic wLane_r, wLane_nxt;
  logic bValid_r, bValid_nxt;
  logic [1:0] bResp_r, bResp_nxt;
  // read channel state
  logic rValid_r, rValid_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic [1:0] rResp_r, rResp_nxt;
  // timebase state
  logic [PRE_W-1:0] pre_r, pre_nxt;
  logic [PHASE_W-1:0] phase_r, phase_nxt;
  logic [FRAME_W-1:0] frame_r, frame_nxt;
  // helpers
  logic awTake, wTake, doWrite, arTake;
  logic [ADDR_W-1:0] wAddr;
  logic [IDX_W-1:0] wIdx, rIdx;
  logic [7:0] wByte;
  logic wLane;
  logic wHit;
  logic [PRE_W-1:0] divMask;
  logic tick;
  logic [NCH-1:0] modOut;

  // handshakes; gated by ce so a frozen block never drops a beat
  assign s_axi_awready = ce && !awHeld_r && !bValid_r;
  assign s_axi_wready = ce && !wHeld_r && !bValid_r;
  assign s_axi_arready = ce && !rValid_r;
  assign awTake = s_axi_awvalid && s_axi_awready;
  assign wTake = s_axi_wvalid && s_axi_wready;
  assign arTake = s_axi_arvalid && s_axi_arready;

  // address and data may arrive in either order; pick held or live copy
  assign wAddr = awHeld_r ? awAddr_r : s_axi_awaddr;
  assign wByte = wHeld_r ? wByte_r : s_axi_wdata[7:0];
  assign wLane = wHeld_r ? wLane_r : s_axi_wstrb[0];
  assign doWrite = (awHeld_r || awTake) && (wHeld_r || wTake);
  assign wIdx = wAddr[ADDR_W-1:ADDR_LSB];
  assign rIdx = s_axi_araddr[ADDR_W-1:ADDR_LSB];

  // write address decode
  always_comb begin
    wHit = (wIdx == IDX_PINCFG) || (wIdx == IDX_CLKCTL) || (wIdx == IDX_STATUS);
    for (int i = 0; i < NCH; i++) begin
      if (wIdx == IDX_LEVEL[i]) begin
        wHit = 1'b1;
      end
    end
  end

  // write channel next state
  always_comb begin
    awHeld_nxt = awHeld_r;
    awAddr_nxt = awAddr_r;
    wHeld_nxt = wHeld_r;
    wByte_nxt = wByte_r;
    wLane_nxt = wLane_r;
    bValid_nxt = bValid_r;
    bResp_nxt = bResp_r;
    if (bValid_r && s_axi_bready) begin
      bValid_nxt = 1'b0;
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt = wHit ? RESP_OKAY : RESP_SLVERR;
    end else begin
      if (awTake) begin
        awHeld_nxt = 1'b1;
        awAddr_nxt = s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_nxt = 1'b1;
        wByte_nxt = s_axi_wdata[7:0];
        wLane_nxt = s_axi_wstrb[0];
      end
    end
  end

  // configuration registers; only byte lane 0 carries data
  always_comb begin
    pinEn_nxt = pinEn_r;
    clkSel_nxt = clkSel_r;
    level_nxt = level_r;
    if (doWrite && wLane) begin
      if (wIdx == IDX_PINCFG) begin
        pinEn_nxt = wByte[PIN_BASE +: NCH]; // RULE9
      end
      if (wIdx == IDX_CLKCTL) begin
        clkSel_nxt = wByte[SEL_W-1:0]; // RULE5
      end
      for (int i = 0; i < NCH; i++) begin
        if (wIdx == IDX_LEVEL[i]) begin
          level_nxt[i] = wByte; // RULE1
        end
      end
    end
  end

  // read channel next state; data captured at the address handshake
  always_comb begin
    rValid_nxt = rValid_r;
    rData_nxt = rData_r;
    rResp_nxt = rResp_r;
    if (rValid_r && s_axi_rready) begin
      rValid_nxt = 1'b0;
    end
    if (arTake) begin
      rValid_nxt = 1'b1;
      rData_nxt = 32'h0000_0000;
      rResp_nxt = RESP_OKAY;
      if (rIdx == IDX_PINCFG) begin
        rData_nxt[PIN_BASE +: NCH] = pinEn_r;
      end else if (rIdx == IDX_CLKCTL) begin
        rData_nxt[SEL_W-1:0] = clkSel_r;
      end else if (rIdx == IDX_STATUS) begin
        rData_nxt[PHASE_W +: FRAME_W] = frame_r;
        rData_nxt[PHASE_W-1:0] = phase_r;
      end else begin
        rResp_nxt = RESP_SLVERR;
      end
      for (int i = 0; i < NCH; i++) begin
        if (rIdx == IDX_LEVEL[i]) begin
          rData_nxt[7:0] = level_r[i];
          rResp_nxt = RESP_OKAY;
        end
      end
    end
  end

  // modulator clock: one tick every 2^(sel+1) input clocks
  assign divMask = {PRE_W{1'b1}} >> (SEL_MAX - clkSel_r); // RULE5
  assign tick = (pre_r & divMask) == divMask; // RULE5

  // timebase: 32-tick basic cycle, eight cycles to a frame
  always_comb begin
    pre_nxt = pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
    phase_nxt = phase_r;
    frame_nxt = frame_r;
    if (tick) begin
      phase_nxt = phase_r + {{(PHASE_W-1){1'b0}}, 1'b1}; // RULE6
      if (phase_r == PHASE_LAST) begin
        frame_nxt = frame_r + {{(FRAME_W-1){1'b0}}, 1'b1}; // RULE4
      end
    end
  end

  // all state registers; ce low freezes everything
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pinEn_r <= PINEN_RST; // RULE8
      clkSel_r <= SEL_RST;
      level_r <= '{default: LEVEL_RST};
      awHeld_r <= 1'b0;
      awAddr_r <= '0;
      wHeld_r <= 1'b0;
      wByte_r <= 8'h00;
      wLane_r <= 1'b0;
      bValid_r <= 1'b0;
      bResp_r <= RESP_OKAY;
      rValid_r <= 1'b0;
      rData_r <= 32'h0000_0000;
      rResp_r <= RESP_OKAY;
      pre_r <= '0;
      phase_r <= '0;
      frame_r <= '0;
    end else if (ce) begin
      pinEn_r <= pinEn_nxt;
      clkSel_r <= clkSel_nxt;
      level_r <= level_nxt;
      awHeld_r <= awHeld_nxt;
      awAddr_r <= awAddr_nxt;
      wHeld_r <= wHeld_nxt;
      wByte_r <= wByte_nxt;
      wLane_r <= wLane_nxt;
      bValid_r <= bValid_nxt;
      bResp_r <= bResp_nxt;
      rValid_r <= rValid_nxt;
      rData_r <= rData_nxt;
      rResp_r <= rResp_nxt;
      pre_r <= pre_nxt;
      phase_r <= phase_nxt;
      frame_r <= frame_nxt;
    end
  end

  assign s_axi_bvalid = bValid_r;
  assign s_axi_bresp = bResp_r;
  assign s_axi_rvalid = rValid_r;
  assign s_axi_rdata = rData_r;
  assign s_axi_rresp = rResp_r;

  // per channel modulator and pin steering
  for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
    fcpd_channel u_chan (
      .clk(clk),
      .reset(reset),
      .ce(ce),
      .phase(phase_r),
      .frame(frame_r),
      .level(level_r[ch]),
      .modOut(modOut[ch])
    );
    // enabled pin is a push-pull modulator output, otherwise the port latch
    assign p1Out[PIN_BASE+ch] = pinEn_r[ch] ? modOut[ch] : ioOut[PIN_BASE+ch]; // RULE7 RULE9
    assign p1Oe[PIN_BASE+ch] = pinEn_r[ch] ? 1'b1 : ioOe[PIN_BASE+ch]; // RULE7
    // each pin follows its own enable, never a neighbour's
    a_pin_route: assert property (@(posedge clk) disable iff (reset) // RULE7
      pinEn_r[ch] |-> p1Out[PIN_BASE+ch] == modOut[ch] && p1Oe[PIN_BASE+ch])
      else $error("enabled pin not on its channel");
    a_pin_plain: assert property (@(posedge clk) disable iff (reset) // RULE7
      !pinEn_r[ch] |-> p1Out[PIN_BASE+ch] == ioOut[PIN_BASE+ch] &&
      p1Oe[PIN_BASE+ch] == ioOe[PIN_BASE+ch])
      else $error("disabled pin not from port latch");
  end

  // low port bits never carry a modulator
  assign p1Out[PIN_BASE-1:0] = ioOut[PIN_BASE-1:0];
  assign p1Oe[PIN_BASE-1:0] = ioOe[PIN_BASE-1:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_pin_steer: assert property (pinEn_r[0] |-> p1Out[PIN_BASE] == modOut[0] && p1Oe[PIN_BASE]) // RULE9
    else $error("channel 0 not on port bit 3");
  a_pin_gpio: assert property (!pinEn_r[NCH-1] |-> p1Out[PORT_W-1] == ioOut[PORT_W-1]) // RULE7
    else $error("disabled pin not plain i/o");
  a_enable_reset: assert property ($fell(reset) |-> pinEn_r == PINEN_RST) // RULE8
    else $error("pin enables not cleared by reset");
  a_sel_reset: assert property ($fell(reset) |-> clkSel_r == SEL_RST) // RULE8
    else $error("clock select not cleared by reset");
  a_div_two: assert property (ce && tick && clkSel_r == 2'h0 ##1 ce // RULE5
    ##1 clkSel_r == 2'h0 |-> tick)
    else $error("divide by two tick missing");
  a_div_four: assert property (ce && tick && clkSel_r == 2'h1 |=> !tick) // RULE5
    else $error("divide by four tick too early");
  a_div_sixteen: assert property (ce && tick && clkSel_r == 2'h3 |=> !tick[*8]) // RULE5
    else $error("divide by sixteen tick too early");
  a_cycle_wrap: assert property (ce && tick && phase_r == PHASE_LAST |=> phase_r == 5'h00 && frame_r == $past(frame_r) + 3'h1) // RULE6
    else $error("basic cycle not 32 ticks");
  a_level_write: assert property (doWrite && wLane && wIdx == IDX_LEVEL[0] && ce |=> level_r[0] == $past(wByte)) // RULE1
    else $error("level write lost");
  a_clk_write: assert property (doWrite && wLane && wIdx == IDX_CLKCTL && ce |=> clkSel_r == $past(wByte[1:0])) // RULE5
    else $error("clock select write lost");

  // answers stand until taken; a dropped answer would lose a register access
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) // RULE1
    else $error("write response dropped early");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> $stable(s_axi_bresp)) // RULE1
    else $error("write response code moved");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) // RULE1
    else $error("read data dropped early");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata)) // RULE1
    else $error("read data moved while waiting");
  a_write_answer: assert property (doWrite && ce |=> s_axi_bvalid) // RULE1
    else $error("write without response");
  a_read_answer: assert property (arTake |=> s_axi_rvalid) // RULE1
    else $error("read without data");
  a_unmapped_write: assert property (doWrite && !wHit && ce |=> s_axi_bresp == RESP_SLVERR) // RULE1
    else $error("unmapped write not refused");

  // refusals: frozen block or pending response takes no new beat
  a_bus_frozen: assert property (!ce |-> !s_axi_awready && !s_axi_wready && !s_axi_arready) // RULE1
    else $error("ready while clock enable low");
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) // RULE1
    else $error("write taken while response pending");

  // read data reflect the register at the address handshake
  a_level_read: assert property (arTake && rIdx == IDX_LEVEL[0] |=> // RULE2
    s_axi_rdata[7:0] == $past(level_r[0]))
    else $error("level read wrong");
  a_pincfg_read: assert property (arTake && rIdx == IDX_PINCFG |=> // RULE9
    s_axi_rdata[PIN_BASE +: NCH] == $past(pinEn_r))
    else $error("pin config read wrong");
  a_status_read: assert property (arTake && rIdx == IDX_STATUS |=> // RULE6
    s_axi_rdata[PHASE_W-1:0] == $past(phase_r))
    else $error("status phase read wrong");

  // clock enable low freezes configuration and timebase alike
  a_pin_hold: assert property (!ce |=> $stable(pinEn_r) && $stable(clkSel_r)) // RULE7
    else $error("configuration moved while frozen");
  a_time_freeze: assert property (!ce |=> $stable(phase_r) && $stable(frame_r)) // RULE6
    else $error("timebase moved while frozen");

  // phase steps by one per tick and idles between ticks
  a_phase_step: assert property (ce && tick && phase_r != PHASE_LAST |=> // RULE6
    phase_r == $past(phase_r) + 5'h01 && $stable(frame_r))
    else $error("phase step wrong");
  a_phase_idle: assert property (ce && !tick |=> $stable(phase_r) && $stable(frame_r)) // RULE6
    else $error("timebase moved without tick");

  // low port bits have no modulator behind them
  a_low_bits: assert property (p1Out[PIN_BASE-1:0] == ioOut[PIN_BASE-1:0] && // RULE9
    p1Oe[PIN_BASE-1:0] == ioOe[PIN_BASE-1:0])
    else $error("low port bits not plain i/o");
endmodule

// ===== fcpd_load_model.sv
`timescale 1ns/100ps
module fcpd_load_model (
  // clock and window control
  input wire logic clk,
  input wire logic clr,
  // pin as the filter sees it
  input wire logic pin,
  input wire logic drv,
  // integrated high time
  output int highCnt
);
  // an rc filter averages the pin; a count of high clocks is its ideal charge
  // an undriven pin adds no charge, whatever level the latch side leaves on it
  always @(posedge clk) begin
    if (clr) begin
      highCnt <= 0;
    end else if (drv === 1'b1 && pin === 1'b1) begin
      highCnt <= highCnt + 1;
    end
  end
endmodule

// ===== tb.sv
`timescale 1ns/100ps
module tb;
  import fcpd_pkg::*;
  logic clk, reset, ce, clr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [PORT_W-1:0] ioOut, ioOe, p1Out, p1Oe;
  int highCnt [NCH];
  int err_total = 0;
  int n_checks = 0;

  fcpd_top u_dut (.clk(clk), .reset(reset), .ce(ce),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .ioOut(ioOut), .ioOe(ioOe), .p1Out(p1Out), .p1Oe(p1Oe));

  // one filter load on every modulator pin
  for (genvar i = 0; i < NCH; i++) begin : g_load
    fcpd_load_model u_load (.clk(clk), .clr(clr), .pin(p1Out[PIN_BASE+i]),
      .drv(p1Oe[PIN_BASE+i]), .highCnt(highCnt[i]));
  end

  // free-running clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic close_out();
    if (err_total == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask

  task automatic hung(input string what);
    $display("Error %s expected handshake seen none", what);
    err_total++;
    close_out();
  endtask

  // one write; address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64 && !(aw && w); n++) begin
      @(posedge clk);
      if (!aw && awready === 1'b1) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w && wready === 1'b1) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (!(aw && w)) hung("writeAccept");
    for (n = 0; n < 64 && bvalid !== 1'b1; n++) @(posedge clk);
    if (bvalid !== 1'b1) hung("writeResp");
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge clk);
      if (arready === 1'b1) break;
    end
    if (arready !== 1'b1) hung("readAccept");
    arvalid <= 1'b0;
    for (n = 0; n < 64 && rvalid !== 1'b1; n++) @(posedge clk);
    if (rvalid !== 1'b1) hung("readData");
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic [11:0] byte_addr(input logic [IDX_W-1:0] idx);
    return {idx, 2'b00};
  endfunction

  // reset state of registers and pins
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(byte_addr(IDX_PINCFG), d, r);
    chk("pinCfgReset", 32'h00000000, d);
    axi_rd(byte_addr(IDX_CLKCTL), d, r);
    chk("clkCtlReset", 32'h00000000, d);
    chk("pinOutIdle", {24'h0, ioOut}, {24'h0, p1Out});
    chk("pinOeIdle", {24'h0, ioOe}, {24'h0, p1Oe});
  endtask

  // every level register holds all eight bits; unmapped places refuse
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    for (int c = 0; c < NCH; c++) begin
      axi_wr(byte_addr(IDX_LEVEL[c]), 8'hC1 + 8'(c * 7), r);
      chk("levelWrResp", {30'h0, RESP_OKAY}, {30'h0, r});
    end
    for (int c = 0; c < NCH; c++) begin
      axi_rd(byte_addr(IDX_LEVEL[c]), d, r);
      chk("levelRead", 32'h000000C1 + 32'(c * 7), d);
    end
    axi_wr(byte_addr(IDX_CLKCTL), 8'hFF, r);
    axi_rd(byte_addr(IDX_CLKCTL), d, r);
    chk("clkCtlWidth", 32'h00000003, d);
    axi_wr(12'h000, 8'h5A, r);
    chk("unmappedWr", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_rd(12'h000, d, r);
    chk("unmappedRd", {30'h0, RESP_SLVERR}, {30'h0, r});
  endtask

  // program one channel, let a frame settle, then integrate one full frame
  task automatic measure(input int c, input logic [1:0] s, input logic [7:0] lv);
    int dv;
    logic [7:0] m;
    logic [1:0] r;
    dv = 2 << s;
    m = 8'h08 << c;
    axi_wr(byte_addr(IDX_CLKCTL), {6'h00, s}, r);
    axi_wr(byte_addr(IDX_LEVEL[c]), lv, r);
    axi_wr(byte_addr(IDX_PINCFG), m, r);
    repeat (256 * dv) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (256 * dv) @(posedge clk);
    #1;
    chk("frameHigh", 32'((8 * lv[7:3] + lv[2:0]) * dv), 32'(highCnt[c]));
    chk("pinOe", {24'h0, (ioOe & ~m) | m}, {24'h0, p1Oe});
    chk("pinOther", {24'h0, ioOut & ~m}, {24'h0, p1Out & ~m});
    @(posedge clk);
  endtask

  // reset again mid-run: enables drop and pins return to the latch
  task automatic t_rereset();
    logic [31:0] d;
    logic [1:0] r;
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("pinOeRereset", {24'h0, ioOe}, {24'h0, p1Oe});
    axi_rd(byte_addr(IDX_PINCFG), d, r);
    chk("pinCfgRereset", 32'h00000000, d);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, clr} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    ce = 1'b1;
    ioOut = 8'hA5;
    ioOe = 8'h3C;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    for (int c = 0; c < NCH; c++) measure(c, 2'h0, {5'd16, 3'd0});
    for (int n = 0; n < 8; n++) measure(0, 2'h1, {5'd4, 3'(n)});
    measure(1, 2'h0, {5'd31, 3'd7});
    for (int s = 0; s < 4; s++) measure(2, 2'(s), {5'd9, 3'd5});
    t_rereset();
    close_out();
  end

  // cut a hung run short
  initial begin
    #700000;
    err_total++;
    close_out();
  end
endmodule
